// ---- common/bcs_pkg.sv ----
// Function
// - restart code re-runs startup when charging disabled
// - startup: host port off except halt, registers other than configuration defaulted
// - boot check retries until pass or halt
// - halted startup restores factory configuration
// - factory check retries forever, uninterruptible
// - both checks passed sets boot ok flag
// - charge enable preset from nonvolatile boot byte, or configuration after command restart
// - trickle: reduced current, stage 000, active
// - full current above threshold, stage 001
// - constant voltage near limit, stage 010
// - constant voltage exit follows configured option
// - reduced voltage only if enabled, stage 011
// - done: power off, stage 100, no faults
// - done restarts on enable rise, auto, command
// - faults checked while active but not done, unlocked and input ok
// - fault stops charging, holds stage, flags source
// - recover when faults clear unless options forbid
// - disconnect wins, clears others, may lock
// - temperature fault freezes low bit, may lock
// - timer fault remeasures battery every five seconds
// - timer fault without voltage restart waits
// - sole low fault remeasures each second, may lock
package bcs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_RESTART = 8'h04;
  localparam logic [7:0] ADDR_HALT    = 8'h08;
  localparam logic [7:0] ADDR_CFG     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_FAULT   = 8'h14;
  localparam logic [7:0] ADDR_VBAT    = 8'h18;
  // command codes
  localparam logic [7:0] RESTART_CODE = 8'h99;
  localparam logic [7:0] HALT_CODE    = 8'h5A;
  // configuration fields
  localparam int CFG_STAGE3  = 0;
  localparam int CFG_CVX_LO  = 1;
  localparam int CFG_TMR_FLT = 3;
  localparam int CFG_NO_DIS  = 4;
  localparam int CFG_NO_TMP  = 5;
  localparam int CFG_NO_VLT  = 6;
  localparam int CFG_NO_LOW  = 7;
  localparam int CFG_INIT_EN = 8;
  localparam int CFG_AUTO    = 9;
  localparam int CFG_HRS_LO  = 16;
  localparam logic [31:0] CFG_FACTORY = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK    = 32'h00FF_03FF;
  // constant-voltage exit options
  localparam logic [1:0] CVX_TERM_LOW = 2'h0;
  localparam logic [1:0] CVX_TERM_TMR = 2'h1;
  localparam logic [1:0] CVX_STAGE3   = 2'h2;
  // status fields
  localparam int ST_STAGE_LO = 0;
  localparam int ST_ACTIVE   = 3;
  localparam int ST_FAULT    = 4;
  localparam int ST_BOOT     = 5;
  localparam int ST_READY    = 6;
  localparam int ST_LOCK     = 7;
  localparam int ST_SOLAR_LO = 8;
  // fault source bits
  localparam int FLT_MISS = 0;
  localparam int FLT_COLD = 1;
  localparam int FLT_HOT  = 2;
  localparam int FLT_LOW  = 3;
  localparam int FLT_TMR  = 4;
  // stage codes and solar states
  localparam logic [2:0] STG_TRICKLE = 3'h0;
  localparam logic [2:0] STG_FULL    = 3'h1;
  localparam logic [2:0] STG_CV      = 3'h2;
  localparam logic [2:0] STG_RCV     = 3'h3;
  localparam logic [2:0] STG_DONE    = 3'h4;
  localparam logic [2:0] SOLAR_OFF   = 3'h0;
  localparam logic [2:0] SOLAR_RUN   = 3'h1;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned MEAS_FAST_S = 1;
  localparam int unsigned MEAS_SLOW_S = 5;
  localparam int unsigned SEC_CYC     = CLK_HZ * MEAS_FAST_S;
  localparam logic [2:0]  SLOW_TICKS  = 3'(MEAS_SLOW_S / MEAS_FAST_S);
  // state machines
  typedef enum logic [2:0] {
    SU_INIT = 3'b000, SU_BOOT_CRC = 3'b001, SU_FACT_DEF = 3'b010,
    SU_FACT_CRC = 3'b011, SU_PRESET = 3'b100, SU_RUN = 3'b101
  } bcs_boot_t;
  typedef enum logic [2:0] {
    CH_OFF = 3'b000, CH_TRICKLE = 3'b001, CH_FULL = 3'b010,
    CH_CV = 3'b011, CH_RCV = 3'b100, CH_DONE = 3'b101
  } bcs_chg_t;
endpackage

// ---- rtl/bcs_top.sv ----
`timescale 1ns/100ps
module bcs_top #(
  parameter int unsigned SEC_CYCLES = bcs_pkg::SEC_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        boot_crc_ok,
  input  wire logic        factory_crc_ok,
  input  wire logic        boot_byte_charge_en,
  input  wire logic        vbat_above_full,
  input  wire logic        vbat_above_cv,
  input  wire logic        iout_below_c10,
  input  wire logic        stage_timer_expired,
  input  wire logic        thermistor_sense_pin,
  input  wire logic        cold_battery,
  input  wire logic        hot_battery,
  input  wire logic        vbat_low,
  input  wire logic [15:0] vbat_sample,
  input  wire logic        input_undervoltage_flag,
  input  wire logic        auto_restart_due,
  input  wire logic        timeout_restart_due,
  output logic             crc_boot_run,
  output logic             crc_factory_run,
  output logic             power_stage_en,
  output logic             trickle_current,
  output logic             cv_regulate,
  output logic             reduced_cv,
  output logic             stage_timer_run,
  output logic             vbat_measure,
  output logic [7:0]       timeout_restart_hours
);
  import bcs_pkg::*;

  bcs_boot_t   su_reg, su_next;
  bcs_chg_t    ch_reg, ch_next;
  logic        aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0]  w_strb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic        chg_en_reg, chg_en_d_reg, halt_reg, cmd_restart_reg, boot_ok_reg;
  logic [31:0] cfg_reg;
  logic [4:0]  flt_reg, flt_next;
  logic        lock_reg, lock_next;
  logic [15:0] vbat_tele_reg;
  logic [31:0] sec_cnt_reg;
  logic [2:0]  slow_cnt_reg;
  logic        meas_reg;
  logic [2:0]  solar_reg;

  // stage code decode, used by the status read only
  function automatic logic [2:0] stage_of(input bcs_chg_t s);
    case (s)
      CH_FULL: stage_of = STG_FULL;
      CH_CV:   stage_of = STG_CV;
      CH_RCV:  stage_of = STG_RCV;
      CH_DONE: stage_of = STG_DONE;
      default: stage_of = STG_TRICKLE;
    endcase
  endfunction

  // bus handshake and write decode
  wire wr_fire   = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire rd_fire   = s_axi_arvalid & ~rvalid_reg;
  wire host_on   = (su_reg == SU_RUN);
  wire wr_lane   = w_strb_reg[0];
  wire wr_halt   = wr_fire & wr_lane & (aw_addr_reg == ADDR_HALT);
  wire wr_ok     = host_on | (aw_addr_reg == ADDR_HALT);
  wire wr_ctrl   = wr_fire & wr_lane & host_on & (aw_addr_reg == ADDR_CTRL);
  wire wr_cfg    = wr_fire & host_on & (aw_addr_reg == ADDR_CFG);
  wire wr_rst    = wr_fire & wr_lane & host_on & (aw_addr_reg == ADDR_RESTART);
  wire restart_q = wr_rst & (w_data_reg[7:0] == RESTART_CODE) & ~chg_en_reg;
  wire halt_q    = wr_halt & (w_data_reg[7:0] == HALT_CODE);
  wire aw_map    = (aw_addr_reg == ADDR_CTRL) | (aw_addr_reg == ADDR_RESTART) |
                   (aw_addr_reg == ADDR_HALT) | (aw_addr_reg == ADDR_CFG) |
                   (aw_addr_reg == ADDR_STATUS) | (aw_addr_reg == ADDR_FAULT) |
                   (aw_addr_reg == ADDR_VBAT);

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // write side: address and data may arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (aw_map & wr_ok) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // status words as seen by software
  wire [31:0] status_word = {21'h00_0000, solar_reg, lock_reg, host_on, boot_ok_reg,
                             |flt_reg, (ch_reg != CH_OFF), stage_of(ch_reg)};
  wire [31:0] rd_word =
    (s_axi_araddr == ADDR_CTRL)   ? {31'h0000_0000, chg_en_reg} :
    (s_axi_araddr == ADDR_CFG)    ? cfg_reg :
    (s_axi_araddr == ADDR_STATUS) ? status_word :
    (s_axi_araddr == ADDR_FAULT)  ? {27'h000_0000, flt_reg} :
    (s_axi_araddr == ADDR_VBAT)   ? {16'h0000, vbat_tele_reg} : 32'h0000_0000;
  wire rd_map = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_RESTART) |
                (s_axi_araddr == ADDR_HALT) | (s_axi_araddr == ADDR_CFG) |
                (s_axi_araddr == ADDR_STATUS) | (s_axi_araddr == ADDR_FAULT) |
                (s_axi_araddr == ADDR_VBAT);

  // read side: one cycle to answer; host port off reads zero with error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= (rd_map & host_on) ? rd_word : 32'h0000_0000;
      rresp_reg  <= (rd_map & host_on) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // startup sequencer
  always_comb
  begin
    su_next = su_reg;
    case (su_reg)
      SU_INIT:     su_next = SU_BOOT_CRC;
      SU_BOOT_CRC:
        if (boot_crc_ok)
          su_next = SU_FACT_CRC;
        else if (halt_reg)
          su_next = SU_FACT_DEF;
      SU_FACT_DEF: su_next = SU_FACT_CRC;
      SU_FACT_CRC:
        if (factory_crc_ok)
          su_next = SU_PRESET;
      SU_PRESET:   su_next = SU_RUN;
      SU_RUN:
        if (restart_q)
          su_next = SU_INIT;
      default:     su_next = SU_INIT;
    endcase
  end

  assign crc_boot_run    = (su_reg == SU_BOOT_CRC);
  assign crc_factory_run = (su_reg == SU_FACT_CRC);

  // control and configuration storage; configuration survives a restart
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      su_reg          <= SU_INIT;
      chg_en_reg      <= 1'b0;
      halt_reg        <= 1'b0;
      cmd_restart_reg <= 1'b0;
      boot_ok_reg     <= 1'b0;
      cfg_reg         <= CFG_FACTORY;
    end
    else
    begin
      su_reg <= su_next;
      if (su_reg == SU_INIT)
      begin
        chg_en_reg  <= 1'b0;
        halt_reg    <= 1'b0;
        boot_ok_reg <= 1'b0;
      end
      if (halt_q & (su_reg == SU_BOOT_CRC))
        halt_reg <= 1'b1;
      if (restart_q)
        cmd_restart_reg <= 1'b1;
      if (su_reg == SU_FACT_DEF)
        cfg_reg <= CFG_FACTORY;
      else if (wr_cfg)
        cfg_reg <= w_data_reg & CFG_MASK;
      if ((su_reg == SU_FACT_CRC) & factory_crc_ok & ~halt_reg)
        boot_ok_reg <= 1'b1;
      if (su_reg == SU_PRESET)
      begin
        // a command restart takes the live initial-enable setting
        chg_en_reg      <= cmd_restart_reg ? cfg_reg[CFG_INIT_EN]
                                           : boot_byte_charge_en;
        cmd_restart_reg <= 1'b0;
      end
      else if (wr_ctrl)
        chg_en_reg <= w_data_reg[0];
    end
  end

  // measurement pacing: one-second tick and five-second tick
  wire sec_tick  = (sec_cnt_reg == 32'(SEC_CYCLES - 1));
  wire slow_tick = sec_tick & (slow_cnt_reg == SLOW_TICKS - 3'h1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_cnt_reg  <= 32'h0000_0000;
      slow_cnt_reg <= 3'h0;
    end
    else
    begin
      sec_cnt_reg <= sec_tick ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
      if (sec_tick)
        slow_cnt_reg <= slow_tick ? 3'h0 : slow_cnt_reg + 3'h1;
    end
  end

  // fault monitor
  wire chg_rise  = chg_en_reg & ~chg_en_d_reg;
  wire charging  = (ch_reg != CH_OFF) & (ch_reg != CH_DONE);
  wire monitor   = charging & ~input_undervoltage_flag & ~lock_reg;
  wire temp_now  = cold_battery | hot_battery;
  wire tmr_hold  = flt_reg[FLT_TMR];
  wire meas_fast = monitor & sec_tick & ~thermistor_sense_pin & ~temp_now & ~tmr_hold;
  wire meas_slow = monitor & slow_tick & tmr_hold & ~cfg_reg[CFG_NO_VLT] &
                   ~thermistor_sense_pin & ~temp_now;
  wire meas_now  = meas_fast | meas_slow;
  wire tmr_rst   = tmr_hold & ((meas_slow & ~vbat_low) |
                   (cfg_reg[CFG_NO_VLT] & timeout_restart_due));

  always_comb
  begin
    flt_next  = flt_reg;
    lock_next = lock_reg;
    if (chg_rise | ~chg_en_reg | (ch_reg == CH_DONE))
    begin
      flt_next  = 5'h00;
      lock_next = 1'b0;
    end
    else if (monitor)
    begin
      if (thermistor_sense_pin)
      begin
        flt_next            = 5'h00;
        flt_next[FLT_MISS]  = 1'b1;
        lock_next           = cfg_reg[CFG_NO_DIS];
      end
      else
      begin
        flt_next[FLT_MISS] = 1'b0;
        flt_next[FLT_COLD] = cold_battery;
        flt_next[FLT_HOT]  = hot_battery;
        if (stage_timer_expired & cfg_reg[CFG_TMR_FLT])
          flt_next[FLT_TMR] = 1'b1;
        if (tmr_rst)
          flt_next[FLT_TMR] = 1'b0;
        if (meas_now)
          flt_next[FLT_LOW] = vbat_low;
        if (temp_now & cfg_reg[CFG_NO_TMP])
          lock_next = 1'b1;
        if (flt_next == 5'h08 & cfg_reg[CFG_NO_LOW])
          lock_next = 1'b1;
      end
    end
  end

  wire fault_on = (|flt_next) | lock_next;
  wire drive_on = charging & ~fault_on & (ch_next != CH_OFF);
  wire [1:0] cvx = cfg_reg[CFG_CVX_LO +: 2];

  // charge stage machine; stage is frozen while a fault stands
  always_comb
  begin
    ch_next = ch_reg;
    if (~host_on | ~chg_en_reg)
      ch_next = CH_OFF;
    else if (tmr_rst)
      ch_next = CH_TRICKLE;
    else if (~fault_on)
    begin
      case (ch_reg)
        CH_OFF:
          if (chg_rise)
            ch_next = CH_TRICKLE;
        CH_TRICKLE:
          if (vbat_above_full)
            ch_next = CH_FULL;
        CH_FULL:
          if (vbat_above_cv)
            ch_next = CH_CV;
        CH_CV:
          if ((cvx == CVX_TERM_LOW) & iout_below_c10)
            ch_next = CH_DONE;
          else if ((cvx == CVX_TERM_TMR) & stage_timer_expired)
            ch_next = CH_DONE;
          else if ((cvx == CVX_STAGE3) & iout_below_c10 & cfg_reg[CFG_STAGE3])
            ch_next = CH_RCV;
        CH_RCV:    ch_next = CH_RCV;
        CH_DONE:
          if (auto_restart_due & cfg_reg[CFG_AUTO])
            ch_next = CH_TRICKLE;
        default:   ch_next = CH_OFF;
      endcase
    end
  end

  // charge state, faults, telemetry and registered drive outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch_reg          <= CH_OFF;
      chg_en_d_reg    <= 1'b0;
      flt_reg         <= 5'h00;
      lock_reg        <= 1'b0;
      vbat_tele_reg   <= 16'h0000;
      meas_reg        <= 1'b0;
      solar_reg       <= SOLAR_OFF;
      power_stage_en  <= 1'b0;
      trickle_current <= 1'b0;
      cv_regulate     <= 1'b0;
      reduced_cv      <= 1'b0;
      stage_timer_run <= 1'b0;
    end
    else
    begin
      ch_reg       <= ch_next;
      chg_en_d_reg <= chg_en_reg;
      flt_reg      <= (su_reg == SU_INIT) ? 5'h00 : flt_next;
      lock_reg     <= (su_reg == SU_INIT) ? 1'b0 : lock_next;
      meas_reg     <= meas_now;
      if (su_reg == SU_INIT)
        vbat_tele_reg <= 16'h0000;
      else if (meas_now)
        vbat_tele_reg <= vbat_sample;
      // power stage off in done, off and during any fault; also off in the
      // cycle enable drops, when the fault clear would otherwise let it pulse
      power_stage_en  <= drive_on;
      trickle_current <= (ch_next == CH_TRICKLE) & ~fault_on;
      cv_regulate     <= ((ch_next == CH_CV) | (ch_next == CH_RCV)) & ~fault_on;
      reduced_cv      <= (ch_next == CH_RCV) & ~fault_on;
      stage_timer_run <= drive_on;
      solar_reg       <= drive_on ? SOLAR_RUN : SOLAR_OFF;
    end
  end

  assign vbat_measure          = meas_reg;
  assign timeout_restart_hours = cfg_reg[CFG_HRS_LO +: 8];
endmodule

// ---- verification/bcs_checker.sv ----
`timescale 1ns/100ps
module bcs_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic boot_crc_ok,
  input wire logic factory_crc_ok,
  input wire logic hot_battery,
  input wire logic input_undervoltage_flag,
  input wire logic crc_boot_run,
  input wire logic crc_factory_run,
  input wire logic power_stage_en,
  input wire logic trickle_current,
  input wire logic cv_regulate,
  input wire logic reduced_cv,
  input wire logic stage_timer_run,
  input wire logic vbat_measure
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // no write under way, so a halt cannot land in this window; a halt taken
  // two edges back only moves the sequencer now, so look that far back
  sequence bus_quiet;
    !s_axi_awvalid && !s_axi_wvalid && !$past(s_axi_awvalid) && !$past(s_axi_wvalid) &&
    !$past(s_axi_awvalid, 2) && !$past(s_axi_wvalid, 2);
  endsequence
  sequence boot_fail;
    crc_boot_run && !boot_crc_ok;
  endsequence
  sequence boot_pass;
    crc_boot_run && boot_crc_ok;
  endsequence
  start_boot_a: assert property ($rose(aresetn) |-> ##[1:2] crc_boot_run)
    else $error("boot check not started after reset");
  boot_retry_a: assert property (boot_fail ##0 bus_quiet |=> crc_boot_run)
    else $error("boot check left while failing");
  boot_pass_a: assert property (boot_pass ##0 bus_quiet |=> crc_factory_run)
    else $error("factory check not entered after boot pass");
  fact_retry_a: assert property (crc_factory_run && !factory_crc_ok |=> crc_factory_run)
    else $error("factory check left while failing");
  crc_excl_a: assert property (!(crc_boot_run && crc_factory_run))
    else $error("both checks running at once");
  stage_excl_a: assert property (!(trickle_current && (cv_regulate || reduced_cv)))
    else $error("trickle current with voltage regulation");
  timer_pause_a: assert property (stage_timer_run |-> power_stage_en)
    else $error("stage timer runs with power stage off");
  hot_stop_a: assert property (hot_battery && !input_undervoltage_flag |=> !power_stage_en)
    else $error("power stage on during hot battery");
  meas_pulse_a: assert property (vbat_measure |=> !vbat_measure)
    else $error("measure pulse longer than one cycle");
endmodule
bind bcs_top bcs_checker bcs_checker_i (.*);

// ---- verification/bcs_plant.sv ----
`timescale 1ns/100ps
// battery model: voltage climbs while the power stage runs
module bcs_plant (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_stage_en,
  input wire logic cv_regulate,
  input wire logic drain,
  output logic     vbat_above_full,
  output logic     vbat_above_cv,
  output logic     iout_below_c10
);
  logic [7:0] lvl_reg;
  // drain empties the cell so a stage can be watched from its start
  always_ff @(posedge aclk)
  begin
    if (!aresetn || drain)
      lvl_reg <= 8'h00;
    else if (power_stage_en && lvl_reg != 8'hFF)
      lvl_reg <= lvl_reg + 8'h01;
  end
  // thresholds spaced so every stage lasts dozens of cycles
  assign vbat_above_full = lvl_reg > 8'h28;
  assign vbat_above_cv   = lvl_reg > 8'h50;
  assign iout_below_c10  = cv_regulate && lvl_reg > 8'h78;
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import bcs_pkg::*;
  localparam int unsigned SECC = 20;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} bcs_note_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, timeout_restart_hours;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic boot_crc_ok, factory_crc_ok, boot_byte_charge_en, vbat_above_full, vbat_above_cv;
  logic iout_below_c10, stage_timer_expired, thermistor_sense_pin, cold_battery, hot_battery;
  logic vbat_low, input_undervoltage_flag, auto_restart_due, timeout_restart_due, drain;
  logic [15:0] vbat_sample;
  logic crc_boot_run, crc_factory_run, power_stage_en, trickle_current, cv_regulate;
  logic reduced_cv, stage_timer_run, vbat_measure;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 92831;
  bcs_note_t q[$];
  bcs_note_t n;

  bcs_top #(.SEC_CYCLES(SECC)) bcs_top_i (.*);
  bcs_plant bcs_plant_i (.*);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic ok, input string s);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp === er, "write response");
  endtask

  // read: the expected word is noted first, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    q.push_back('{d, m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
  endtask

  // result monitor, oldest note first
  always @(posedge aclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && q.size() > 0)
    begin
      n = q.pop_front();
      if ((((s_axi_rdata ^ n.d) & n.m) !== 32'h0000_0000) || (s_axi_rresp !== n.r))
      begin
        bad_count++;
        $display("MISMATCH %0t read %h resp %h", $time, s_axi_rdata, s_axi_rresp);
      end
      cmp_count++;
    end
  end

  // polls the status word until the stage shows, active bit set
  task automatic poll(input logic [2:0] code);
    repeat (200)
    begin
      rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY);
      if (rv[2:0] === code && rv[ST_ACTIVE] === 1'b1) break;
    end
    chk(rv[2:0] === code && rv[ST_ACTIVE] === 1'b1, "stage code");
  endtask

  // hang guard, far above the expected run length
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      close_out();
    end
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, vbat_sample} = '0;
    {boot_crc_ok, factory_crc_ok, boot_byte_charge_en, stage_timer_expired} = '0;
    {thermistor_sense_pin, cold_battery, hot_battery, vbat_low, drain} = '0;
    {input_undervoltage_flag, auto_restart_due, timeout_restart_due} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
    repeat (10) @(posedge aclk);
    boot_crc_ok <= 1'b1;
    repeat (10) @(posedge aclk);
    factory_crc_ok <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(ADDR_STATUS, 32'h0000_0060, 32'h0000_0078, RESP_OKAY);
    rd(ADDR_CTRL, 32'h0000_0000, 32'h0000_0001, RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_CFG, 32'h0003_0105, RESP_OKAY);
    rd(ADDR_CFG, 32'h0003_0105, 32'hFFFF_FFFF, RESP_OKAY);
    chk(timeout_restart_hours === 8'h03, "restart hours");
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    poll(STG_TRICKLE);
    chk(trickle_current === 1'b1, "trickle current");
    poll(STG_FULL);
    poll(STG_CV);
    poll(STG_RCV);
    chk(reduced_cv === 1'b1, "reduced voltage");
    hot_battery <= 1'b1;
    repeat (3 * SECC) @(posedge aclk);
    rd(ADDR_STATUS, 32'h0000_001B, 32'h0000_071F, RESP_OKAY);
    rd(ADDR_FAULT, 32'h1 << FLT_HOT, 32'h0000_001F, RESP_OKAY);
    chk(power_stage_en === 1'b0, "power during fault");
    thermistor_sense_pin <= 1'b1;
    cold_battery <= 1'b1;
    repeat (3 * SECC) @(posedge aclk);
    rd(ADDR_FAULT, 32'h1 << FLT_MISS, 32'h0000_001F, RESP_OKAY);
    {thermistor_sense_pin, cold_battery, hot_battery} <= 3'h0;
    repeat (3 * SECC) @(posedge aclk);
    rd(ADDR_STATUS, 32'h0000_0008, 32'h0000_0018, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    drain <= 1'b1;
    wr(ADDR_CFG, 32'h0003_0100, RESP_OKAY);
    drain <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    poll(STG_DONE);
    chk(power_stage_en === 1'b0, "power in done");
    hot_battery <= 1'b1;
    repeat (3 * SECC) @(posedge aclk);
    rd(ADDR_FAULT, 32'h0000_0000, 32'h0000_001F, RESP_OKAY);
    hot_battery <= 1'b0;
    drain <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    poll(STG_TRICKLE);
    vbat_sample <= 16'($random(seed));
    vbat_low <= 1'b1;
    repeat (3 * SECC) @(posedge aclk);
    rd(ADDR_FAULT, 32'h1 << FLT_LOW, 32'h0000_001F, RESP_OKAY);
    rd(ADDR_VBAT, {16'h0000, vbat_sample}, 32'hFFFF_FFFF, RESP_OKAY);
    {input_undervoltage_flag, hot_battery} <= 2'b11;
    repeat (3 * SECC) @(posedge aclk);
    rd(ADDR_FAULT, 32'h1 << FLT_LOW, 32'h0000_001F, RESP_OKAY);
    {input_undervoltage_flag, hot_battery} <= 2'b00;
    wr(ADDR_CFG, 32'h0003_0108, RESP_OKAY);
    stage_timer_expired <= 1'b1;
    vbat_sample <= 16'($random(seed));
    repeat (6 * SECC) @(posedge aclk);
    rd(ADDR_FAULT, 32'h0000_0018, 32'h0000_001F, RESP_OKAY);
    rd(ADDR_VBAT, {16'h0000, vbat_sample}, 32'hFFFF_FFFF, RESP_OKAY);
    {stage_timer_expired, vbat_low} <= 2'b00;
    repeat (6 * SECC) @(posedge aclk);
    rd(ADDR_FAULT, 32'h0000_0000, 32'h0000_001F, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_RESTART, {24'h00_0000, RESTART_CODE}, RESP_OKAY);
    repeat (12) @(posedge aclk);
    rd(ADDR_CTRL, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    poll(STG_TRICKLE);
    wr(ADDR_CFG, 32'h0003_0120, RESP_OKAY);
    hot_battery <= 1'b1;
    repeat (SECC) @(posedge aclk);
    hot_battery <= 1'b0;
    repeat (3 * SECC) @(posedge aclk);
    rd(ADDR_STATUS, 32'h0000_0098, 32'h0000_0098, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    boot_crc_ok <= 1'b0;
    wr(ADDR_RESTART, {24'h00_0000, RESTART_CODE}, RESP_OKAY);
    repeat (5) @(posedge aclk);
    wr(ADDR_HALT, {24'h00_0000, HALT_CODE}, RESP_OKAY);
    boot_crc_ok <= 1'b1;
    repeat (12) @(posedge aclk);
    rd(ADDR_CFG, CFG_FACTORY, 32'hFFFF_FFFF, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0020, RESP_OKAY);
    repeat (4) @(posedge aclk);
    close_out();
  end
endmodule
